// *** common/erqf_pkg.sv ***
// Constants and state layout for the external request flag block.
package erqf_pkg;
  localparam int          ERQF_NSRC   = 6;         // External request inputs.
  localparam int          ERQF_AW     = 4;         // Register address width.
  localparam int          ERQF_DW     = 16;        // Register data width.
  localparam int          ERQF_VW     = 16;        // Vector address width.
  localparam logic [3:0]  A_FLAGS     = 4'h0;      // external_request_flags.
  localparam logic [3:0]  A_SENSE     = 4'h2;      // request_sense_control.
  localparam logic [3:0]  A_CPU_EN    = 4'h4;      // CPU request enables.
  localparam logic [3:0]  A_XFER_EN   = 4'h6;      // Transfer start enables.
  localparam logic [3:0]  A_OVR_STAT  = 4'h8;      // Lost event status.
  localparam logic [3:0]  A_OVR_CLR   = 4'ha;      // Lost event clear.
  localparam logic [3:0]  A_OVR_EN    = 4'hc;      // Lost event enables.
  localparam logic [5:0]  FLAGS_RST   = 6'h00;     // Flags after reset.
  localparam logic [5:0]  PINS_IDLE   = 6'h3f;     // Request pins idle high.
  localparam logic [1:0]  RSV_ZERO    = 2'h0;      // Reserved bits 7 and 6.
  localparam logic [11:0] SENSE_RST   = 12'h000;   // All inputs low level.
  localparam logic [15:0] VEC_STEP    = 16'h0004;  // Bytes per vector entry.

  // Sense selection, two bits per input.
  typedef enum logic [1:0] {
    SENSE_LOW  = 2'b00,
    SENSE_FALL = 2'b01,
    SENSE_RISE = 2'b10,
    SENSE_BOTH = 2'b11
  } erqf_sense_e;

  // Whole state of the block.
  typedef struct packed {
    logic [5:0]  s1;        // Input synchroniser, first stage.
    logic [5:0]  s2;        // Second stage.
    logic [5:0]  s3;        // Third stage.
    logic [5:0]  lvl;       // Filtered input level.
    logic [5:0]  flags;     // Request flags.
    logic [5:0]  arm;       // Flag read as one, clear allowed.
    logic [5:0]  clr_pend;  // Software clears awaiting instruction end.
    logic [11:0] sense;     // Sense selection per input.
    logic [5:0]  cpu_en;    // Enables as written by software.
    logic [5:0]  eff_en;    // Enables in force.
    logic [5:0]  xfer_en;   // Transfer controller start enables.
    logic [5:0]  ovr;       // Lost event status.
    logic [5:0]  ovr_en;    // Lost event enables.
    logic [15:0] rdata;     // Read data.
    logic        req;       // CPU request.
    logic [2:0]  req_id;    // CPU request source.
    logic [15:0] vec;       // Vector table address.
    logic        xreq;      // Transfer controller request.
    logic [2:0]  xid;       // Transfer request source.
    logic        int_o;     // Lost event interrupt.
  } erqf_state_s;
endpackage

// *** verilog/erqf_top.sv ***
// Request flag logic for six external interrupt inputs.
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ps
module erqf_top #(
  parameter logic [15:0] VEC_BASE = 16'h0040  // Vector of input 0.
) (
  input  wire logic                          CLK_I,
  input  wire logic                          RST_N_I,
  input  wire logic                          CE_I,
  input  wire logic [erqf_pkg::ERQF_AW-1:0]  ADDR_I,
  input  wire logic [erqf_pkg::ERQF_DW-1:0]  WDATA_I,
  input  wire logic                          WR_I,
  input  wire logic                          RD_I,
  output logic      [erqf_pkg::ERQF_DW-1:0]  RDATA_O,
  input  wire logic [erqf_pkg::ERQF_NSRC-1:0] REQ_IN_I,
  input  wire logic                          INSN_DONE_I,
  input  wire logic                          EXC_ACK_I,
  input  wire logic [2:0]                    EXC_SRC_I,
  input  wire logic                          XFER_START_I,
  input  wire logic [2:0]                    XFER_SRC_I,
  input  wire logic                          XFER_DISABLE_I,
  output logic                               REQ_O,
  output logic      [2:0]                    REQ_ID_O,
  output logic      [erqf_pkg::ERQF_VW-1:0]  VEC_O,
  output logic                               XFER_REQ_O,
  output logic      [2:0]                    XFER_ID_O,
  output logic                               INT_O
);
  import erqf_pkg::*;

  // Vector entries are whole words, so the base must be aligned.
  if (VEC_BASE[1:0] != 2'h0) begin : g_bad_base
    $error("VEC_BASE must be word aligned");
  end

  // Combinational helpers below are filled by the next-state process, except cpu_pend_w and xfr_pend_w.
  erqf_state_s st;       // Registered state.
  erqf_state_s nx;       // Next state.
  logic [5:0]  set_w;    // Flags set this cycle.
  logic [5:0]  exc_clr_w; // Flags cleared by exception handling.
  logic [5:0]  xfr_clr_w; // Flags cleared by transfer start.
  logic [5:0]  sw_clr_w; // Flags cleared by software.
  logic [5:0]  cpu_pend_w; // Flags that may request the CPU.
  logic [5:0]  xfr_pend_w; // Flags that may start a transfer.
  logic [5:0]  lost_w;   // Events lost on flags already set.

  // Lowest index wins; the fixed order keeps priority simple and predictable.
  function automatic logic [3:0] prio(input logic [5:0] m);
    logic [3:0] r;
    r = 4'h0;
    // Scanning downward lets the lowest set index write the result last.
    for (int i = ERQF_NSRC - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  // One-hot decode of a source number, ignoring numbers past the inputs.
  function automatic logic [5:0] onehot(input logic [2:0] n);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 0; i < ERQF_NSRC; i++) begin
      if (n == 3'(i)) begin
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction

  // Next state: inputs, flags, registers and requests.
  always_comb begin
    logic [5:0]  lvl_n;
    logic [5:0]  hot;
    logic [3:0]  pc;
    logic [3:0]  px;
    erqf_sense_e sel;
    lvl_n = st.lvl;
    hot = 6'h00;
    pc = 4'h0;
    px = 4'h0;
    sel = SENSE_LOW;
    nx = st;
    set_w = 6'h00;
    exc_clr_w = 6'h00;
    xfr_clr_w = 6'h00;
    sw_clr_w = 6'h00;
    lost_w = 6'h00;
    // Three stages; a change counts once stages two and three agree.
    nx.s1 = REQ_IN_I;
    nx.s2 = st.s1;
    nx.s3 = st.s2;
    for (int i = 0; i < ERQF_NSRC; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        lvl_n[i] = st.s3[i];
      end
    end
    nx.lvl = lvl_n;
    // Event detection per input.
    // The filtered level of the previous cycle is the reference for edges.
    for (int i = 0; i < ERQF_NSRC; i++) begin
      sel = erqf_sense_e'(st.sense[2*i +: 2]);
      case (sel)
        SENSE_LOW: begin
          set_w[i] = ~lvl_n[i];
        end
        SENSE_FALL: begin
          set_w[i] = st.lvl[i] & ~lvl_n[i];
        end
        SENSE_RISE: begin
          set_w[i] = ~st.lvl[i] & lvl_n[i];
        end
        SENSE_BOTH: begin
          set_w[i] = st.lvl[i] ^ lvl_n[i];
        end
        default: begin
          set_w[i] = 1'b0;
        end
      endcase
    end
    // Exception handling clears; a held low level keeps its flag.
    if (EXC_ACK_I) begin
      // Source numbers past the last input select nothing.
      hot = onehot(EXC_SRC_I);
      for (int i = 0; i < ERQF_NSRC; i++) begin
        if (st.sense[2*i +: 2] == SENSE_LOW) begin
          exc_clr_w[i] = hot[i] & st.lvl[i];
        end else begin
          exc_clr_w[i] = hot[i];
        end
      end
    end
    // A transfer start clears unless the controller keeps the flag.
    if (XFER_START_I && !XFER_DISABLE_I) begin
      xfr_clr_w = onehot(XFER_SRC_I);
    end
    // Software clears are held until the writing instruction ends.
    if (INSN_DONE_I) begin
      // CPU enables and clears written during the instruction land together; transfer enables apply at once.
      sw_clr_w = st.clr_pend;
      nx.clr_pend = 6'h00;
      nx.eff_en = st.cpu_en;
    end
    // A set beats any clear landing in the same cycle.
    nx.flags = (st.flags & ~(exc_clr_w | xfr_clr_w | sw_clr_w)) | set_w;
    // An event on a flag already set would be lost, so record it.
    lost_w = set_w & st.flags & ~(exc_clr_w | xfr_clr_w | sw_clr_w);
    nx.ovr = st.ovr | lost_w;
    // Read data, registered so it stands in the cycle after the strobe.
    nx.rdata = 16'h0000;
    if (RD_I) begin
      case (ADDR_I)
        A_FLAGS: begin
          // Reading arms every flag that is set at this moment.
          nx.rdata = {8'h00, RSV_ZERO, st.flags};
          nx.arm = st.arm | st.flags;
        end
        A_SENSE: begin
          nx.rdata = {4'h0, st.sense};
        end
        A_CPU_EN: begin
          nx.rdata = {10'h000, st.cpu_en};
        end
        A_XFER_EN: begin
          nx.rdata = {10'h000, st.xfer_en};
        end
        A_OVR_STAT: begin
          nx.rdata = {10'h000, st.ovr};
        end
        A_OVR_EN: begin
          nx.rdata = {10'h000, st.ovr_en};
        end
        default: begin
          nx.rdata = 16'h0000;
        end
      endcase
    end
    // Register writes; unmapped addresses are ignored.
    if (WR_I) begin
      case (ADDR_I)
        A_FLAGS: begin
          // Only armed bits written zero are queued; any write disarms every flag.
          nx.clr_pend = nx.clr_pend | (st.arm & ~WDATA_I[5:0]);
          nx.arm = 6'h00;
        end
        A_SENSE: begin
          nx.sense = WDATA_I[11:0];
        end
        A_CPU_EN: begin
          nx.cpu_en = WDATA_I[5:0];
        end
        A_XFER_EN: begin
          nx.xfer_en = WDATA_I[5:0];
        end
        A_OVR_CLR: begin
          // A lost event in the same cycle as its clear stays recorded.
          nx.ovr = (st.ovr & ~WDATA_I[5:0]) | lost_w;
        end
        A_OVR_EN: begin
          nx.ovr_en = WDATA_I[5:0];
        end
        default: begin
          // Other addresses leave every register as it is.
          nx.ovr_en = st.ovr_en;
        end
      endcase
    end
    // Arming is lost once the flag has dropped by other means.
    nx.arm = nx.arm & nx.flags;
    // CPU requests use the enables in force, so a late event is still taken; transfer requests use xfer_en as written.
    pc = prio(cpu_pend_w);
    nx.req = pc[3];
    nx.req_id = pc[2:0];
    nx.vec = VEC_BASE + 16'(pc[2:0]) * VEC_STEP;
    px = prio(xfr_pend_w);
    nx.xreq = px[3];
    nx.xid = px[2:0];
    nx.int_o = |(nx.ovr & st.ovr_en);
  end

  // The CPU path sees the enables in force, not the ones just written.
  assign cpu_pend_w = st.flags & st.eff_en;
  assign xfr_pend_w = st.flags & st.xfer_en;

  // State register; clock enable low freezes everything.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st <= '0;
      st.flags <= FLAGS_RST;
      st.sense <= SENSE_RST;
      // Synchroniser and filter start at the idle pin level, so leaving reset
      // looks like neither a low level nor a falling edge on every input.
      st.s1 <= PINS_IDLE;
      st.s2 <= PINS_IDLE;
      st.s3 <= PINS_IDLE;
      st.lvl <= PINS_IDLE;
    end else if (CE_I) begin
      st <= nx;
    end
  end

  // Every output comes straight from the state register.
  assign RDATA_O = st.rdata;
  assign REQ_O = st.req;
  assign REQ_ID_O = st.req_id;
  assign VEC_O = st.vec;
  assign XFER_REQ_O = st.xreq;
  assign XFER_ID_O = st.xid;
  assign INT_O = st.int_o;

  // Reserved flag bits always read back as zero.
  chk_reserved_zero: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CE_I && RD_I && ADDR_I == A_FLAGS |=> RDATA_O[7:6] == 2'h0)
    else $error("reserved flag bits read non-zero");

  // A detected event leaves its flag set.
  chk_event_sets: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CE_I && set_w != 6'h00 |=> (st.flags & $past(set_w)) == $past(set_w))
    else $error("event did not set its flag");

  // A write of zero queues a clear only for armed flags.
  chk_arm_gate: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CE_I && WR_I && ADDR_I == A_FLAGS
    |=> (st.clr_pend & ~$past(st.clr_pend) & ~$past(st.arm)) == 6'h00)
    else $error("clear queued without prior read");

  // Exception handling clears the chosen flag unless an event re-sets it.
  chk_exc_clear: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CE_I && exc_clr_w != 6'h00 |=> (st.flags & $past(exc_clr_w) & ~$past(set_w)) == 6'h00)
    else $error("exception handling left flag set");

  // Low level held at acceptance keeps the flag.
  // A transfer start or instruction end may legally clear it, so those are left out.
  chk_low_keeps: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CE_I && EXC_ACK_I && (onehot(EXC_SRC_I) & ~st.lvl & ~{st.sense[10], st.sense[8],
    st.sense[6], st.sense[4], st.sense[2], st.sense[0]} & ~{st.sense[11], st.sense[9],
    st.sense[7], st.sense[5], st.sense[3], st.sense[1]} & st.flags) != 6'h00
    && !XFER_START_I && !INSN_DONE_I |=> (st.flags & $past(onehot(EXC_SRC_I))) != 6'h00)
    else $error("low level flag cleared at exception");

  // Transfer start with disable low clears the flag.
  chk_xfer_clear: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CE_I && xfr_clr_w != 6'h00 |=> (st.flags & $past(xfr_clr_w) & ~$past(set_w)) == 6'h00)
    else $error("transfer start left flag set");

  // CPU enables in force change only when an instruction ends.
  chk_delay_en: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CE_I && !INSN_DONE_I |=> st.eff_en == $past(st.eff_en))
    else $error("enable took effect mid-instruction");

  // Without an instruction end, only hardware clears drop flags.
  chk_flag_hold: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CE_I && !INSN_DONE_I |=> ($past(st.flags) & ~st.flags & ~$past(exc_clr_w)
    & ~$past(xfr_clr_w)) == 6'h00)
    else $error("flag dropped without a clear");

  // The request names the highest-priority pending source.
  chk_prio_pick: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CE_I && cpu_pend_w != 6'h00 |=> REQ_O && (($past(cpu_pend_w) >> REQ_ID_O) & 6'h01) == 6'h01
    && ($past(cpu_pend_w) & ((6'h01 << REQ_ID_O) - 6'h01)) == 6'h00)
    else $error("wrong request priority");

  // The vector follows the requesting source.
  chk_vector: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    REQ_O |-> VEC_O == VEC_BASE + 16'(REQ_ID_O) * VEC_STEP)
    else $error("vector address mismatch");

  // Transfer requests follow the transfer enables.
  chk_xfer_req: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CE_I |=> XFER_REQ_O == ($past(xfr_pend_w) != 6'h00))
    else $error("transfer request mismatch");

  // A lost event survives a clear written in the same cycle.
  chk_lost_kept: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CE_I && lost_w != 6'h00 |=> (st.ovr & $past(lost_w)) == $past(lost_w))
    else $error("lost event not recorded");

  // Queued software clears land at the instruction end.
  chk_sw_clear: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CE_I && INSN_DONE_I && st.clr_pend != 6'h00
    |=> (st.flags & $past(st.clr_pend) & ~$past(set_w)) == 6'h00)
    else $error("queued clear did not land");

  // Read data stand for one cycle only, then fall back to zero.
  chk_rdata_idle: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CE_I && !RD_I |=> RDATA_O == 16'h0000)
    else $error("read data outside the read cycle");
endmodule

// *** sim/erqf_cpu_model.sv ***
// Model of the CPU exception logic and transfer controller facing the flag block.
`timescale 1ns/1ps
module erqf_cpu_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ack_on_i,   // Take CPU requests.
  input  wire logic       xfer_on_i,  // Start transfers on requests.
  input  wire logic       keep_i,     // Transfer keeps the flag.
  input  wire logic       slow_i,     // Long gap between answers.
  input  wire logic       req_i,
  input  wire logic [2:0] req_id_i,
  input  wire logic       xreq_i,
  input  wire logic [2:0] xid_i,
  output logic            ack_o,
  output logic      [2:0] src_o,
  output logic            xstart_o,
  output logic      [2:0] xsrc_o,
  output logic            xdis_o
);
  int hold;  // Cycles before the next answer may be given.
  // One answer at a time; the gap lets a cleared flag reach the request outputs.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold     <= 0;
      ack_o    <= 1'b0;
      xstart_o <= 1'b0;
      src_o    <= 3'h0;
      xsrc_o   <= 3'h0;
      xdis_o   <= 1'b0;
    end else begin
      ack_o    <= 1'b0;
      xstart_o <= 1'b0;
      // Idle lines do not keep the last source, so a stale value cannot pass.
      src_o    <= ~src_o;
      xsrc_o   <= ~xsrc_o;
      xdis_o   <= ~xdis_o;
      if (hold > 0) begin
        hold <= hold - 1;
      end else if (ack_on_i && req_i) begin
        ack_o <= 1'b1;
        src_o <= req_id_i;
        hold  <= slow_i ? 12 : 4;
      end else if (xfer_on_i && xreq_i) begin
        xstart_o <= 1'b1;
        xsrc_o   <= xid_i;
        xdis_o   <= keep_i;
        hold     <= slow_i ? 12 : 4;
      end
    end
  end
endmodule

// *** sim/erqf_top_test.sv ***
// Self-checking testbench of the external request flag block.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin mismatches++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module erqf_top_test;
  import erqf_pkg::*;
  localparam logic [15:0] VB = 16'h0100;  // Vector base under test.
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, insn = 1'b0;
  logic        ack_on = 1'b0, xfer_on = 1'b0, keep = 1'b0, slow = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata, vec, d;
  logic [5:0]  req_in = 6'h3f, exp_flags = 6'h00, r;  // Pins idle high; model flags.
  logic        ack, xstart, xdis, req, xreq, intr;
  logic [2:0]  src, xsrc, req_id, xid;
  int          mismatches = 0, checked = 0, mode = 0;
  integer      seed = 32'ha5b55b91;
  erqf_top #(.VEC_BASE(VB)) dut_u (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .REQ_IN_I(req_in), .INSN_DONE_I(insn),
    .EXC_ACK_I(ack), .EXC_SRC_I(src), .XFER_START_I(xstart), .XFER_SRC_I(xsrc), .XFER_DISABLE_I(xdis),
    .REQ_O(req), .REQ_ID_O(req_id), .VEC_O(vec), .XFER_REQ_O(xreq), .XFER_ID_O(xid), .INT_O(intr));
  erqf_cpu_model cpu_u (.clk_i(clk), .rst_n_i(rst_n), .ack_on_i(ack_on), .xfer_on_i(xfer_on),
    .keep_i(keep), .slow_i(slow), .req_i(req), .req_id_i(req_id), .xreq_i(xreq), .xid_i(xid),
    .ack_o(ack), .src_o(src), .xstart_o(xstart), .xsrc_o(xsrc), .xdis_o(xdis));
  always #25 clk = ~clk;
  // Read data is taken in the one cycle where it stands.
  task automatic bus_rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk); rd <= 1'b1; addr <= a;
    @(posedge clk); rd <= 1'b0;
    @(negedge clk); v = rdata;
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk); wr <= 1'b1; addr <= a; wdata <= v;
    @(posedge clk); wr <= 1'b0;
  endtask
  task automatic insn_end();
    @(posedge clk); insn <= 1'b1;
    @(posedge clk); insn <= 1'b0;
  endtask
  // Events that the chosen sense makes from an old and a new pin level.
  function automatic logic [5:0] hits(input logic [5:0] o, input logic [5:0] n);
    case (mode)
      0: hits = ~n;
      1: hits = o & ~n;
      2: hits = ~o & n;
      default: hits = o ^ n;
    endcase
  endfunction
  // Eight cycles cover the synchroniser and the filter.
  task automatic pins(input logic [5:0] v);
    @(posedge clk); req_in <= v;
    exp_flags |= hits(req_in, v);
    repeat (8) @(posedge clk);
  endtask
  task automatic chk_flags();
    bus_rd(A_FLAGS, d);
    `CHK("flags", {10'h000, exp_flags}, d)
  endtask
  // Read arms the flags, the write of zero waits for the instruction end.
  task automatic clr(input logic [5:0] m);
    chk_flags();
    bus_wr(A_FLAGS, {10'h000, ~m});
    insn_end();
    exp_flags &= ~m;
    if (mode == 0) exp_flags |= ~req_in;
    chk_flags();
  endtask
  task automatic chk_req(input logic en);
    int id;
    id = 0;
    while (id < 5 && !exp_flags[id]) id++;
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK("req", en && exp_flags != 0, req)
    if (req === 1'b1) begin
      `CHK("id", id[2:0], req_id)
      `CHK("vec", VB + 16'(4 * id), vec)
    end
  endtask
  task automatic chk_int(input logic v);
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK("int", v, intr)
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // The filter starts at the idle level, so no register may show anything yet.
    for (int a = 0; a < 16; a++) begin
      bus_rd(a[3:0], d);
      `CHK("reset", 16'h0000, d)
    end
    repeat (8) @(posedge clk);
    bus_rd(A_FLAGS, d);
    bus_wr(A_FLAGS, 16'h0000);
    insn_end();
    // Every sense mode against random pin patterns, clearing while masked.
    for (mode = 0; mode < 4; mode++) begin
      bus_wr(A_SENSE, {4'h0, {6{mode[1:0]}}});
      r = 6'($random(seed));
      pins(r);
      chk_flags();
      pins(6'h3f);
      clr(6'h3f);
    end
    mode = 1;
    bus_wr(A_SENSE, 16'h0555);
    pins(6'h00);
    bus_rd(A_FLAGS, d);
    bus_wr(A_FLAGS, 16'h003f);  // Writing ones drops the arming.
    bus_wr(A_FLAGS, 16'h0000);
    insn_end();
    chk_flags();
    bus_rd(A_FLAGS, d);
    bus_wr(A_FLAGS, 16'h003e);
    chk_flags();
    insn_end();
    exp_flags = 6'h3e;
    chk_flags();
    bus_wr(A_CPU_EN, 16'h003f);
    insn_end();
    chk_req(1'b1);
    bus_wr(A_CPU_EN, 16'h0000);
    chk_req(1'b1);
    insn_end();
    chk_req(1'b0);
    bus_wr(A_CPU_EN, 16'h003f);
    insn_end();
    ack_on <= 1'b1;
    repeat (60) @(posedge clk);
    exp_flags = 6'h00;
    chk_flags();
    // Pins return high under falling sense first, so low sense starts from idle.
    pins(6'h3f);
    mode = 0;
    bus_wr(A_SENSE, 16'h0000);
    pins(6'h3e);
    repeat (30) @(posedge clk);
    chk_flags();
    pins(6'h3f);
    repeat (20) @(posedge clk);
    exp_flags = 6'h00;
    chk_flags();
    ack_on = 1'b0;
    mode = 1;
    bus_wr(A_SENSE, 16'h0555);
    bus_wr(A_CPU_EN, 16'h0000);
    insn_end();
    bus_wr(A_XFER_EN, 16'h003f);
    pins(6'h00);
    @(negedge clk);
    `CHK("xreq", 1'b1, xreq)
    `CHK("xid", 3'h0, xid)
    chk_req(1'b0);
    keep = 1'b1;
    xfer_on = 1'b1;
    slow = 1'b1;
    repeat (40) @(posedge clk);
    chk_flags();
    keep = 1'b0;
    repeat (120) @(posedge clk);
    exp_flags = 6'h00;
    chk_flags();
    xfer_on = 1'b0;
    pins(6'h3f);
    bus_wr(A_OVR_CLR, 16'h003f);
    pins(6'h3e);
    pins(6'h3f);
    pins(6'h3e);
    bus_rd(A_OVR_STAT, d);
    `CHK("lost", 16'h0001, d)
    chk_int(1'b0);
    bus_wr(A_OVR_EN, 16'h0001);
    chk_int(1'b1);
    bus_wr(A_OVR_CLR, 16'h0001);
    chk_int(1'b0);
    give_verdict();
  end
endmodule
